// >>> src/ras_pkg.sv
package ras_pkg;

  // ----------------------------------------
  // Register map and widths
  // ----------------------------------------
  localparam logic [6:0] CALL_STACK_INDEX_ADDR = 7'h01;
  localparam int         INDEX_W               = 4;
  localparam int         SLOT_W                = 16;
  localparam int         SLOT_COUNT            = 15;
  localparam logic [3:0] INDEX_RESET           = 4'hF;
  localparam logic [3:0] MISSING_TOP_SLOT      = 4'hF;
  localparam logic [15:0] RESTART_ADDR         = 16'h0000;

  // ----------------------------------------
  // Stack operations from the sequencer
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE          = 4'h0,
    OP_CALL          = 4'h1,
    OP_SUB_RETURN    = 4'h2,
    OP_TABLE_READ    = 4'h3,
    OP_IRQ_ENTRY     = 4'h4,
    OP_IRQ_RETURN    = 4'h5,
    OP_PUSH          = 4'h6,
    OP_POP           = 4'h7,
    OP_SYSTEM_CALL   = 4'h8,
    OP_SYSTEM_RETURN = 4'h9
  } stack_op_e;

  // Request from the sequencer
  typedef struct packed {
    stack_op_e   op;
    logic [15:0] return_addr;
    logic [15:0] code_address_reg;
  } stack_req_s;

  // Answer to the sequencer
  typedef struct packed {
    logic        pc_load;
    logic [15:0] pc_value;
    logic        car_load;
    logic [15:0] car_value;
    logic        fault;
  } stack_rsp_s;

  // Table read phases
  typedef enum logic [2:0] {
    TR_IDLE   = 3'b001,
    TR_FETCH  = 3'b010,
    TR_RETURN = 3'b100
  } table_state_e;

endpackage

// >>> src/stack_index_counter.sv
`timescale 1ns/1ps
module stack_index_counter (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Controls
  input  wire logic       force_top,
  input  wire logic       clock_stopped,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_data,
  input  wire logic       dec,
  input  wire logic       inc,
  // State
  output logic      [3:0] index,
  output logic            underflow,
  output logic            overflow
);
  logic [3:0] index_reg;
  logic [3:0] index_next;

  always_comb begin
    index_next = index_reg;
    underflow  = 1'b0;
    overflow   = 1'b0;
    if (force_top) begin
      index_next = ras_pkg::INDEX_RESET;
    end else if (clock_stopped) begin
      index_next = index_reg;
    end else if (wr_en) begin
      index_next = wr_data;
    end else if (dec) begin
      index_next = index_reg - 4'h1;
      overflow   = (index_reg == 4'h0);
    end else if (inc) begin
      index_next = index_reg + 4'h1;
      underflow  = (index_reg == ras_pkg::MISSING_TOP_SLOT);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      index_reg <= ras_pkg::INDEX_RESET;
    end else begin
      index_reg <= index_next;
    end
  end

  assign index = index_reg;
endmodule // stack_index_counter

// >>> src/return_slot_array.sv
`timescale 1ns/1ps
module return_slot_array #(
  parameter int SLOTS = ras_pkg::SLOT_COUNT
) (
  // Clock
  input  wire logic        core_clk,
  // Port
  input  wire logic [3:0]  index,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data
);
  logic [15:0] return_slot [SLOTS];

  // Slots hold no reset value
  always_ff @(posedge core_clk) begin
    if (wr_en && (index < 4'(SLOTS))) begin
      return_slot[index] <= wr_data;
    end
  end

  always_comb begin
    if (index < 4'(SLOTS)) begin
      rd_data = return_slot[index];
    end else begin
      rd_data = 16'h0000;
    end
  end
endmodule // return_slot_array

// >>> src/return_address_stack.sv
`timescale 1ns/1ps
// What this block does
// - Four-bit counter indexes the return slots
// - Index readable and writable at address 01H
// - Indexes 0-14 select slots; 0FH prohibited
// - Index forced to 0FH on resets
// - Index held while clock stopped
// - Call decrements index then stores return
// - Return loads PC then increments index
// - Table read saves, fetches, restores, adjusts index
// - Interrupt entry decrements and stores return
// - Interrupt return restores PC, increments index
// - Push decrements and stores code address
// - Pop loads code address, increments index
// - System call stores return and segment
// - System return restores PC and segment
// - Top slot unstored; nesting over 15 undefined
// - Optional reset on overflow or underflow
// - Fault reset selection taken at power-on or pin reset
// - Slots are 16 bits; fifteen stored
module return_address_stack (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                nrst,
  // Reset sources and clock stop
  input  wire logic                power_on_reset,
  input  wire logic                pin_reset,
  input  wire logic                ce_reset,
  input  wire logic                watchdog_reset,
  input  wire logic                clock_stopped,
  input  wire logic                fault_reset_select,
  // Register port
  input  wire logic [6:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [3:0]          reg_wdata,
  output logic      [3:0]          reg_rdata,
  // Sequencer request and answer
  input  wire ras_pkg::stack_req_s req,
  input  wire logic [3:0]          segment_reg,
  input  wire logic [15:0]         program_word,
  output ras_pkg::stack_rsp_s      rsp,
  output logic      [3:0]          segment_value,
  output logic                     segment_load,
  output logic                     table_fetch,
  output logic      [15:0]         table_addr,
  output logic      [15:0]         transfer_buffer,
  output logic                     transfer_buffer_load,
  output logic                     watchdog_stack_fault_reset
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [3:0]           index;
  logic                 idx_dec;
  logic                 idx_inc;
  logic                 idx_wr;
  logic                 underflow;
  logic                 overflow;
  logic                 slot_wr;
  logic [15:0]          slot_wdata;
  logic [15:0]          slot_rdata;
  logic                 force_top;
  logic                 fault_en_reg;
  logic                 fault_en_next;
  logic                 fault_reg;
  logic                 fault_next;
  ras_pkg::table_state_e tr_reg;
  ras_pkg::table_state_e tr_next;
  logic [15:0]          tr_addr_reg;
  logic [15:0]          tr_addr_next;
  ras_pkg::stack_rsp_s  rsp_reg;
  ras_pkg::stack_rsp_s  rsp_next;
  logic [3:0]           seg_reg;
  logic [3:0]           seg_next;
  logic                 seg_ld_reg;
  logic                 seg_ld_next;
  logic [15:0]          dbf_reg;
  logic [15:0]          dbf_next;
  logic                 dbf_ld_reg;
  logic                 dbf_ld_next;

  function automatic logic is_pop_kind(input ras_pkg::stack_op_e op);
    return (op == ras_pkg::OP_SUB_RETURN) || (op == ras_pkg::OP_IRQ_RETURN) ||
           (op == ras_pkg::OP_POP) || (op == ras_pkg::OP_SYSTEM_RETURN);
  endfunction

  function automatic logic is_push_kind(input ras_pkg::stack_op_e op);
    return (op == ras_pkg::OP_CALL) || (op == ras_pkg::OP_IRQ_ENTRY) ||
           (op == ras_pkg::OP_PUSH) || (op == ras_pkg::OP_SYSTEM_CALL);
  endfunction

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  assign force_top = power_on_reset || pin_reset || ce_reset ||
                     watchdog_reset || fault_reg;

  stack_index_counter u_index (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .force_top     (force_top),
    .clock_stopped (clock_stopped),
    .wr_en         (idx_wr),
    .wr_data       (reg_wdata),
    .dec           (idx_dec),
    .inc           (idx_inc),
    .index         (index),
    .underflow     (underflow),
    .overflow      (overflow)
  );

  return_slot_array #(
    .SLOTS (ras_pkg::SLOT_COUNT)
  ) u_slots (
    .core_clk (core_clk),
    .index    (index),
    .wr_en    (slot_wr),
    .wr_data  (slot_wdata),
    .rd_data  (slot_rdata)
  );

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  assign idx_wr    = reg_wr && (reg_addr == ras_pkg::CALL_STACK_INDEX_ADDR) &&
                     (tr_reg == ras_pkg::TR_IDLE);
  assign reg_rdata = (reg_addr == ras_pkg::CALL_STACK_INDEX_ADDR) ? index : 4'h0;

  // ----------------------------------------
  // Stack operations
  // ----------------------------------------
  // Pushes store through the slot at the already-decremented index: the
  // write is taken one edge after the decrement, when the index points there.
  logic        push_pend_reg;
  logic        push_pend_next;
  logic [15:0] push_data_reg;
  logic [15:0] push_data_next;

  always_comb begin
    idx_dec        = 1'b0;
    idx_inc        = 1'b0;
    slot_wr        = 1'b0;
    slot_wdata     = push_data_reg;
    push_pend_next = 1'b0;
    push_data_next = push_data_reg;
    tr_next        = tr_reg;
    tr_addr_next   = tr_addr_reg;
    rsp_next       = '0;
    seg_next       = seg_reg;
    seg_ld_next    = 1'b0;
    dbf_next       = dbf_reg;
    dbf_ld_next    = 1'b0;
    if (push_pend_reg) begin
      slot_wr = 1'b1;
    end
    if (clock_stopped || force_top) begin
      tr_next = ras_pkg::TR_IDLE;
    end else begin
      case (tr_reg)
        ras_pkg::TR_IDLE: begin
          if (is_push_kind(req.op)) begin
            idx_dec        = 1'b1;
            push_pend_next = 1'b1;
            case (req.op)
              ras_pkg::OP_PUSH:        push_data_next = req.code_address_reg;
              ras_pkg::OP_SYSTEM_CALL: push_data_next = {segment_reg, req.return_addr[11:0]};
              default:                 push_data_next = req.return_addr;
            endcase
          end else if (is_pop_kind(req.op)) begin
            idx_inc = 1'b1;
            case (req.op)
              ras_pkg::OP_POP: begin
                rsp_next.car_load  = 1'b1;
                rsp_next.car_value = slot_rdata;
              end
              ras_pkg::OP_SYSTEM_RETURN: begin
                rsp_next.pc_load  = 1'b1;
                rsp_next.pc_value = {4'h0, slot_rdata[11:0]};
                seg_next          = slot_rdata[15:12];
                seg_ld_next       = 1'b1;
              end
              default: begin
                rsp_next.pc_load  = 1'b1;
                rsp_next.pc_value = slot_rdata;
              end
            endcase
          end else if (req.op == ras_pkg::OP_TABLE_READ) begin
            idx_inc        = 1'b1;
            push_pend_next = 1'b1;
            push_data_next = req.return_addr;
            tr_addr_next   = req.code_address_reg;
            tr_next        = ras_pkg::TR_FETCH;
          end
        end
        ras_pkg::TR_FETCH: begin
          dbf_next    = program_word;
          dbf_ld_next = 1'b1;
          tr_next     = ras_pkg::TR_RETURN;
        end
        ras_pkg::TR_RETURN: begin
          rsp_next.pc_load  = 1'b1;
          rsp_next.pc_value = slot_rdata;
          idx_inc           = 1'b1;
          tr_next           = ras_pkg::TR_IDLE;
        end
        default: tr_next = ras_pkg::TR_IDLE;
      endcase
    end
    rsp_next.fault = fault_reg;
  end

  // ----------------------------------------
  // Overflow and underflow reset
  // ----------------------------------------
  always_comb begin
    fault_en_next = fault_en_reg;
    if (power_on_reset || pin_reset) begin
      fault_en_next = fault_reset_select;
    end
    fault_next = fault_en_reg && (overflow || underflow) && !force_top;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fault_en_reg  <= 1'b0;
      fault_reg     <= 1'b0;
      tr_reg        <= ras_pkg::TR_IDLE;
      tr_addr_reg   <= 16'h0000;
      rsp_reg       <= '0;
      seg_reg       <= 4'h0;
      seg_ld_reg    <= 1'b0;
      dbf_reg       <= 16'h0000;
      dbf_ld_reg    <= 1'b0;
      push_pend_reg <= 1'b0;
      push_data_reg <= 16'h0000;
    end else begin
      fault_en_reg  <= fault_en_next;
      fault_reg     <= fault_next;
      tr_reg        <= tr_next;
      tr_addr_reg   <= tr_addr_next;
      rsp_reg       <= rsp_next;
      seg_reg       <= seg_next;
      seg_ld_reg    <= seg_ld_next;
      dbf_reg       <= dbf_next;
      dbf_ld_reg    <= dbf_ld_next;
      push_pend_reg <= push_pend_next;
      push_data_reg <= push_data_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    rsp = rsp_reg;
    rsp.fault = fault_reg;
    if (fault_reg) begin
      rsp.pc_load  = 1'b1;
      rsp.pc_value = ras_pkg::RESTART_ADDR;
    end
  end

  assign segment_value              = seg_reg;
  assign segment_load               = seg_ld_reg;
  assign table_fetch                = (tr_reg == ras_pkg::TR_FETCH);
  assign table_addr                 = tr_addr_reg;
  assign transfer_buffer            = dbf_reg;
  assign transfer_buffer_load       = dbf_ld_reg;
  assign watchdog_stack_fault_reset = fault_reg;
endmodule // return_address_stack

// >>> bench/return_address_stack_props.sv
`timescale 1ns/1ps
module return_address_stack_props (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                nrst,
  // Inputs
  input wire logic                power_on_reset,
  input wire logic                pin_reset,
  input wire logic                ce_reset,
  input wire logic                watchdog_reset,
  input wire logic                clock_stopped,
  input wire logic                fault_reset_select,
  input wire logic [6:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic [3:0]          reg_wdata,
  input wire ras_pkg::stack_req_s req,
  // Outputs
  input wire logic [3:0]          reg_rdata,
  input wire ras_pkg::stack_rsp_s rsp,
  input wire logic                segment_load,
  input wire logic                table_fetch,
  input wire logic                transfer_buffer_load,
  input wire logic                watchdog_stack_fault_reset
);
  logic any_rst, quiet, push_op, pop_op, sel_reg, sel_next;
  assign any_rst = power_on_reset | pin_reset | ce_reset | watchdog_reset;
  assign quiet = !any_rst && !clock_stopped && !reg_wr && !watchdog_stack_fault_reset
                 && reg_addr == 7'h01 && !table_fetch && !transfer_buffer_load;
  assign push_op = req.op inside {ras_pkg::OP_CALL, ras_pkg::OP_IRQ_ENTRY, ras_pkg::OP_PUSH,
                                  ras_pkg::OP_SYSTEM_CALL};
  assign pop_op = req.op inside {ras_pkg::OP_SUB_RETURN, ras_pkg::OP_IRQ_RETURN,
                                 ras_pkg::OP_POP, ras_pkg::OP_SYSTEM_RETURN};
  // ----------------------------------------
  // Fault reset selection tracker
  // ----------------------------------------
  always_comb begin
    sel_next = sel_reg;
    if (power_on_reset || pin_reset) begin
      sel_next = fault_reset_select;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sel_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_RESET_TOP: assert property (any_rst && reg_addr == 7'h01 |=>
    reg_addr != 7'h01 || reg_rdata == ras_pkg::INDEX_RESET) else $error("index not at top");
  AST_HOLD_STOP: assert property (clock_stopped && !any_rst && !reg_wr
    && !watchdog_stack_fault_reset && reg_addr == 7'h01 |=> $stable(reg_rdata))
    else $error("index moved in stop");
  AST_PUSH_DEC: assert property (quiet && push_op |=>
    reg_rdata == $past(reg_rdata) - 4'h1) else $error("push index wrong");
  AST_POP_INC: assert property (quiet && pop_op |=>
    reg_rdata == $past(reg_rdata) + 4'h1) else $error("pop index wrong");
  AST_RET_PC: assert property (quiet && req.op inside {ras_pkg::OP_SUB_RETURN,
    ras_pkg::OP_IRQ_RETURN} |=> rsp.pc_load && !rsp.car_load) else $error("no pc load");
  AST_POP_CAR: assert property (quiet && req.op == ras_pkg::OP_POP |=>
    rsp.car_load && !rsp.pc_load) else $error("no car load");
  AST_SYS_RET: assert property (quiet && req.op == ras_pkg::OP_SYSTEM_RETURN |=>
    rsp.pc_load && segment_load) else $error("no segment load");
  AST_TABLE_SEQ: assert property (quiet && req.op == ras_pkg::OP_TABLE_READ |=>
    ##[0:1] table_fetch ##[1:2] transfer_buffer_load ##[1:2] rsp.pc_load)
    else $error("table read sequence wrong");
  AST_TABLE_NET: assert property (quiet && req.op == ras_pkg::OP_TABLE_READ |->
    ##4 reg_rdata == $past(reg_rdata, 4) + 4'h2) else $error("table read index wrong");
  AST_REG_WR: assert property (reg_wr && reg_addr == 7'h01 && !any_rst && !clock_stopped
    && req.op == ras_pkg::OP_NONE && !watchdog_stack_fault_reset && !table_fetch
    && !transfer_buffer_load |=>
    reg_rdata == $past(reg_wdata)) else $error("index write lost");
  AST_UNMAPPED: assert property (reg_addr != 7'h01 |-> reg_rdata == 4'h0)
    else $error("unmapped read not zero");
  AST_FAULT: assert property (watchdog_stack_fault_reset |-> rsp.pc_load
    && rsp.fault && rsp.pc_value == ras_pkg::RESTART_ADDR ##1 !watchdog_stack_fault_reset)
    else $error("fault reset wrong");
  AST_FAULT_SEL: assert property (!sel_reg |-> !watchdog_stack_fault_reset)
    else $error("fault reset not selected");
  COV_PUSH: cover property (quiet && push_op);
  COV_TABLE: cover property (transfer_buffer_load);
  COV_FAULT: cover property (watchdog_stack_fault_reset);
endmodule // return_address_stack_props

bind return_address_stack return_address_stack_props u_props (.core_clk, .nrst,
  .power_on_reset, .pin_reset, .ce_reset, .watchdog_reset, .clock_stopped,
  .fault_reset_select, .reg_addr, .reg_wr, .reg_wdata, .req, .reg_rdata, .rsp,
  .segment_load, .table_fetch, .transfer_buffer_load, .watchdog_stack_fault_reset);

// >>> bench/program_memory_model.sv
`timescale 1ns/1ps
module program_memory_model (
  // Clock
  input  wire logic        core_clk,
  // Fetch from the block
  input  wire logic        table_fetch,
  input  wire logic [15:0] table_addr,
  // Fetched word
  output logic      [15:0] program_word
);
  logic [15:0] churn_reg = 16'h0000;
  // Bus churns when no fetch is made
  always_ff @(posedge core_clk) churn_reg <= churn_reg + 16'h9E37;
  assign program_word = table_fetch ? {table_addr[7:0], ~table_addr[15:8]} : churn_reg;
endmodule // program_memory_model

// >>> bench/return_address_stack_bench.sv
`timescale 1ns/1ps
module return_address_stack_bench;
  logic                core_clk, nrst, clock_stopped, fault_reset_select, reg_wr;
  logic                segment_load, table_fetch, transfer_buffer_load, fault_pulse;
  logic [3:0]          rst_src, reg_wdata, reg_rdata, segment_reg, segment_value, exp_idx;
  logic [6:0]          reg_addr;
  logic [15:0]         program_word, table_addr, transfer_buffer, ra, car, v;
  ras_pkg::stack_req_s req;
  ras_pkg::stack_rsp_s rsp;
  ras_pkg::stack_op_e  k;
  ras_pkg::stack_op_e  kind_q[$];
  logic [15:0]         slot_q[$];
  int                  err_count, n_checks, n;
  ras_pkg::stack_op_e  pk[4] = '{ras_pkg::OP_CALL, ras_pkg::OP_IRQ_ENTRY, ras_pkg::OP_PUSH,
                                 ras_pkg::OP_SYSTEM_CALL};

  return_address_stack uut (.core_clk, .nrst, .power_on_reset(rst_src[0]),
    .pin_reset(rst_src[1]), .ce_reset(rst_src[2]), .watchdog_reset(rst_src[3]),
    .clock_stopped, .fault_reset_select, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .req,
    .segment_reg, .program_word, .rsp, .segment_value, .segment_load, .table_fetch,
    .table_addr, .transfer_buffer, .transfer_buffer_load,
    .watchdog_stack_fault_reset(fault_pulse));
  program_memory_model u_mem (.core_clk, .table_fetch, .table_addr, .program_word);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic idx_is(input logic [3:0] e);
    check({12'h000, reg_rdata}, {12'h000, e});
  endtask
  task automatic issue(input ras_pkg::stack_op_e op, input logic [15:0] a,
                       input logic [15:0] c, input logic [3:0] s);
    @(posedge core_clk);
    req <= '{op: op, return_addr: a, code_address_reg: c};
    segment_reg <= s;
    @(posedge core_clk);
    req.op <= ras_pkg::OP_NONE;
    #1;
  endtask
  task automatic wr_idx(input logic [3:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic pulse(input int i, input logic sel);
    @(posedge core_clk);
    rst_src[i] <= 1'b1;
    fault_reset_select <= sel;
    @(posedge core_clk);
    rst_src[i] <= 1'b0;
    #1;
  endtask
  task automatic wait_hi(input int s);
    for (int i = 0; i < 10 && !(s == 0 ? transfer_buffer_load : s == 1 ? rsp.pc_load
         : fault_pulse); i++) @(posedge core_clk) #1;
    if (!(s == 0 ? transfer_buffer_load : s == 1 ? rsp.pc_load : fault_pulse)) begin
      err_count++;
      $display("BAD %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  function automatic logic [15:0] slot_of(input ras_pkg::stack_op_e op, input logic [3:0] s);
    if (op == ras_pkg::OP_PUSH) return car;
    if (op == ras_pkg::OP_SYSTEM_CALL) return {s, ra[11:0]};
    return ra;
  endfunction

  initial begin
    {nrst, clock_stopped, fault_reset_select, reg_wr, reg_wdata, segment_reg} = '0;
    {err_count, n_checks} = '0;
    rst_src = 4'h1;
    reg_addr = 7'h01;
    req = '0;
    void'($urandom(32'hCD38));
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rst_src <= 4'h0;
    @(posedge core_clk) #1;
    exp_idx = 4'hF;
    idx_is(exp_idx);
    @(posedge core_clk);
    reg_addr <= 7'h05;
    @(posedge core_clk) #1;
    idx_is(4'h0);
    @(posedge core_clk);
    reg_addr <= 7'h01;
    for (n = 0; n < 60; n++) begin
      ra = 16'($urandom);
      car = 16'($urandom);
      if (slot_q.size() == 0 || (slot_q.size() < 14 && $urandom_range(1, 0) == 1)) begin
        k = pk[$urandom_range(3, 0)];
        v = 16'($urandom);
        issue(k, ra, car, v[3:0]);
        kind_q.push_back(k);
        slot_q.push_back(slot_of(k, v[3:0]));
        exp_idx = exp_idx - 4'h1;
      end else begin
        k = kind_q.pop_back();
        v = slot_q.pop_back();
        issue(k == ras_pkg::OP_CALL ? ras_pkg::OP_SUB_RETURN : k == ras_pkg::OP_PUSH
              ? ras_pkg::OP_POP : k == ras_pkg::OP_IRQ_ENTRY ? ras_pkg::OP_IRQ_RETURN
              : ras_pkg::OP_SYSTEM_RETURN, ra, car, 4'h0);
        exp_idx = exp_idx + 4'h1;
        if (k == ras_pkg::OP_PUSH) check(rsp.car_value, v);
        else if (k != ras_pkg::OP_SYSTEM_CALL) check(rsp.pc_value, v);
        else check({v[15:12], rsp.pc_value[11:0]}, {segment_value, v[11:0]});
      end
      idx_is(exp_idx);
    end
    @(posedge core_clk);
    clock_stopped <= 1'b1;
    issue(ras_pkg::OP_CALL, ra, car, 4'h0);
    idx_is(exp_idx);
    @(posedge core_clk);
    clock_stopped <= 1'b0;
    for (n = 0; n < 4; n++) begin
      wr_idx(4'h3);
      idx_is(4'h3);
      pulse(n, 1'b0);
      idx_is(4'hF);
    end
    wr_idx(4'h5);
    issue(ras_pkg::OP_TABLE_READ, ra, car, 4'h0);
    wait_hi(0);
    check(transfer_buffer, {car[7:0], ~car[15:8]});
    check(table_addr, car);
    wait_hi(1);
    check(rsp.pc_value, ra);
    idx_is(4'h7);
    pulse(0, 1'b1);
    wr_idx(4'h0);
    issue(ras_pkg::OP_CALL, ra, car, 4'h0);
    wait_hi(2);
    check(rsp.pc_value, ras_pkg::RESTART_ADDR);
    @(posedge core_clk) #1;
    idx_is(4'hF);
    pulse(1, 1'b0);
    issue(ras_pkg::OP_SUB_RETURN, ra, car, 4'h0);
    check(rsp.pc_value, 16'h0000);
    repeat (3) @(posedge core_clk) #1;
    check({15'h0000, fault_pulse}, 16'h0000);
    wrap_up();
  end
endmodule // return_address_stack_bench
